// ===== logic/tbf_consts.svh
`ifndef TBF_CONSTS_SVH
`define TBF_CONSTS_SVH

// preamble octets
`define TBF_PRE_FIRST    8'h55
`define TBF_PRE_SECOND   8'hFF

// frame type codes
`define TBF_FT_TOKEN     8'h00
`define TBF_FT_POLL      8'h01
`define TBF_FT_POLL_REPLY 8'h02
`define TBF_FT_IPV6      8'h0A

// node id values
`define TBF_ID_BCAST     8'hFF
`define TBF_ID_NONE      8'h00
`define TBF_ID_UNI_MAX   8'h7F

// payload bounds in octets: 1500 max, 1280 least datagram
`define TBF_MAX_LEN      16'h05DC
`define TBF_MIN_MTU      16'h0500

// data check value is four octets, counted 0..3
`define TBF_DCRC_LAST    2'h3

// dispatch octets and field positions
`define TBF_DISP_EXT     8'h40
`define TBF_DISP_IPV6    8'h41
`define TBF_DISP_TOP     7:6
`define TBF_DISP_HDRC    7:5

// payload buffer
`define TBF_FIFO_DEPTH   16
`define TBF_FIFO_SLACK   3

`endif

// ===== logic/tbf_pkg.sv
package tbf_pkg;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_PRE  = 4'b0001,
		ST_TYPE = 4'b0010,
		ST_DST  = 4'b0011,
		ST_SRC  = 4'b0100,
		ST_LENH = 4'b0101,
		ST_LENL = 4'b0110,
		ST_HCRC = 4'b0111,
		ST_DISP = 4'b1000,
		ST_ESC  = 4'b1001,
		ST_DATA = 4'b1010,
		ST_DCRC = 4'b1011
	} tbf_state_t;

	typedef enum logic [1:0] {
		RT_NONE = 2'b00,
		RT_IPV6 = 2'b01,
		RT_HDRC = 2'b10,
		RT_EXT  = 2'b11
	} tbf_route_t;

endpackage : tbf_pkg

// ===== logic/tbf_fifo_if.sv
`timescale 1ns/1ns
// payload buffer handshake, write and read sides
interface tbf_fifo_if #(
	parameter int W  = 9,
	parameter int LW = 5
);
	logic          wr_vld;
	logic          wr_rdy;
	logic [W-1:0]  wr_data;
	logic          rd_vld;
	logic          rd_rdy;
	logic [W-1:0]  rd_data;
	logic [LW-1:0] level;

	modport fifo (input wr_vld, input wr_data, output wr_rdy,
		output rd_vld, output rd_data, input rd_rdy, output level);
	modport user (output wr_vld, output wr_data, input wr_rdy,
		input rd_vld, input rd_data, output rd_rdy, input level);
endinterface : tbf_fifo_if

// ===== logic/tbf_fifo.sv
`timescale 1ns/1ns
`include "tbf_consts.svh"
module tbf_fifo import tbf_pkg::*; #(
	parameter int W = 9,
	parameter int D = `TBF_FIFO_DEPTH
) (
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	tbf_fifo_if.fifo  f
);
	localparam int AW = $clog2(D);

	logic [W-1:0]  mem [D];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0]   cnt_r;
	logic          out_vld_r;
	logic [W-1:0]  out_data_r;
	logic          push;
	logic          pop;

	// output stage is a register so the reader sees flop outputs
	assign f.wr_rdy  = cnt_r < (AW+1)'(D);
	assign push      = f.wr_vld && f.wr_rdy;
	assign pop       = (cnt_r != '0) && (!out_vld_r || f.rd_rdy);
	assign f.rd_vld  = out_vld_r;
	assign f.rd_data = out_data_r;
	assign f.level   = cnt_r;

	// storage, no reset needed on data
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr_r] <= f.wr_data;
		end
	end

	// pointers and occupancy
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			cnt_r    <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// read register refills whenever empty or taken
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			out_vld_r  <= 1'b0;
			out_data_r <= '0;
		end else if (pop) begin
			out_vld_r  <= 1'b1;
			out_data_r <= mem[rd_ptr_r];
		end else if (f.rd_rdy) begin
			out_vld_r  <= 1'b0;
		end
	end

	a_fifo_no_overflow: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		f.wr_vld |-> f.wr_rdy)
		else $error("payload buffer written while full");
	c_fifo_full: cover property (@(posedge clk_i) disable iff (!rst_b_i)
		cnt_r == (AW+1)'(D));

endmodule : tbf_fifo

// ===== logic/tbf_frame_filter.sv
`timescale 1ns/1ns
`include "tbf_consts.svh"
module tbf_frame_filter import tbf_pkg::*; #(
	parameter int FIFO_D = `TBF_FIFO_DEPTH
) (
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	input  wire logic [7:0] own_id_i,
	input  wire logic [7:0] rx_octet_i,
	input  wire logic       rx_octet_vld_i,
	output logic            rx_ready_o,
	output logic            ctl_evt_o,
	output logic [1:0]      ctl_type_o,
	output logic [7:0]      ctl_src_o,
	output logic [7:0]      pay_data_o,
	output logic            pay_last_o,
	output logic            pay_valid_o,
	input  wire logic       pay_ready_i,
	output logic [1:0]      route_o,
	output logic [7:0]      dispatch_o,
	output logic            bcast_o,
	output logic            addr_err_o,
	output logic            len_err_o,
	output logic            disp_drop_o,
	input  wire logic       tx_req_i,
	input  wire logic       tx_mcast_i,
	input  wire logic [7:0] tx_dst_i,
	output logic            tx_go_o,
	output logic            tx_reject_o,
	output logic [7:0]      tx_ftype_o,
	output logic [7:0]      tx_dst_o,
	output logic [7:0]      tx_src_o
);
	localparam int LW = $clog2(FIFO_D) + 1;

	tbf_fifo_if #(.W(9), .LW(LW)) pf ();

	logic        rst_s1_b_r;
	logic        rst_q_b_r;
	tbf_state_t  st_r;
	logic [7:0]  ftype_r;
	logic [7:0]  dst_r;
	logic [7:0]  src_r;
	logic [15:0] len_r;
	logic [15:0] left_r;
	logic [1:0]  crc_cnt_r;
	logic        keep_r;
	logic        rx_rdy_r;
	logic        take;
	logic        last_oct;
	logic        uni_ok_dst;
	logic        id_bad;
	logic        ctl_type;
	logic        ctl_evt_r;
	logic [1:0]  ctl_type_r;
	logic [7:0]  ctl_src_r;
	tbf_route_t  route_r;
	logic [7:0]  dispatch_r;
	logic        bcast_r;
	logic        addr_err_r;
	logic        len_err_r;
	logic        disp_drop_r;
	logic        tx_go_r;
	logic        tx_reject_r;
	logic        tx_mc_r;
	logic [7:0]  tx_ftype_r;
	logic [7:0]  tx_dst_r;
	logic [7:0]  tx_src_r;
	logic [7:0]  tx_dst_pick;
	logic        tx_ok;

	// reset released through two flops
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_s1_b_r <= 1'b0;
			rst_q_b_r  <= 1'b0;
		end else begin
			rst_s1_b_r <= 1'b1;
			rst_q_b_r  <= rst_s1_b_r;
		end
	end

	// octet source is same-clock UART logic, so no synchroniser
	assign take     = rx_octet_vld_i && rx_rdy_r;
	assign last_oct = left_r == 16'h0001;
	assign ctl_type = ftype_r <= `TBF_FT_POLL_REPLY;
	assign id_bad   = (src_r == `TBF_ID_NONE) || (src_r == `TBF_ID_BCAST) || (dst_r == `TBF_ID_NONE);

	// frame walker: preamble, header, dispatch, data, check octets
	always_ff @(posedge clk_i or negedge rst_q_b_r) begin
		if (!rst_q_b_r) begin
			st_r      <= ST_IDLE;
			ftype_r   <= 8'h00;
			dst_r     <= 8'h00;
			src_r     <= 8'h00;
			len_r     <= 16'h0000;
			left_r    <= 16'h0000;
			crc_cnt_r <= 2'h0;
		end else if (take) begin
			case (st_r)
				ST_IDLE: begin
					if (rx_octet_i == `TBF_PRE_FIRST) begin
						st_r <= ST_PRE;
					end
				end
				ST_PRE: begin
					if (rx_octet_i == `TBF_PRE_SECOND) begin
						st_r <= ST_TYPE;
					end else if (rx_octet_i != `TBF_PRE_FIRST) begin
						st_r <= ST_IDLE;
					end
				end
				ST_TYPE: begin
					ftype_r <= rx_octet_i;
					st_r    <= ST_DST;
				end
				ST_DST: begin
					dst_r <= rx_octet_i;
					st_r  <= ST_SRC;
				end
				ST_SRC: begin
					src_r <= rx_octet_i;
					st_r  <= ST_LENH;
				end
				ST_LENH: begin
					len_r[15:8] <= rx_octet_i;
					st_r        <= ST_LENL;
				end
				ST_LENL: begin
					len_r[7:0] <= rx_octet_i;
					st_r       <= ST_HCRC;
				end
				ST_HCRC: begin
					// header check is verified by the UART layer, only skipped here
					left_r    <= len_r;
					crc_cnt_r <= 2'h0;
					st_r      <= (len_r == 16'h0000) ? ST_IDLE : ST_DISP;
				end
				ST_DISP: begin
					left_r <= left_r - 16'h0001;
					if (last_oct) begin
						st_r <= ST_DCRC;
					end else if (rx_octet_i == `TBF_DISP_EXT) begin
						st_r <= ST_ESC;
					end else begin
						st_r <= ST_DATA;
					end
				end
				ST_ESC, ST_DATA: begin
					left_r <= left_r - 16'h0001;
					if (last_oct) begin
						st_r <= ST_DCRC;
					end else begin
						st_r <= ST_DATA;
					end
				end
				ST_DCRC: begin
					// four check octets, 32-bit value
					crc_cnt_r <= crc_cnt_r + 2'h1;
					if (crc_cnt_r == `TBF_DCRC_LAST) begin
						st_r <= ST_IDLE;
					end
				end
				default: begin
					st_r <= ST_IDLE;
				end
			endcase
		end
	end

	// header verdict: accept IPv6 frames for us or broadcast
	always_ff @(posedge clk_i or negedge rst_q_b_r) begin
		if (!rst_q_b_r) begin
			keep_r     <= 1'b0;
			bcast_r    <= 1'b0;
			addr_err_r <= 1'b0;
			len_err_r  <= 1'b0;
		end else begin
			addr_err_r <= 1'b0;
			len_err_r  <= 1'b0;
			if (take && st_r == ST_HCRC) begin
				keep_r <= 1'b0;
				if (ftype_r == `TBF_FT_IPV6 && len_r != 16'h0000) begin
					if (id_bad) begin
						addr_err_r <= 1'b1;
					end else if (len_r > `TBF_MAX_LEN) begin
						len_err_r <= 1'b1;
					end else if (dst_r == `TBF_ID_BCAST) begin
						keep_r  <= 1'b1;
						bcast_r <= 1'b1;
					end else if (dst_r == own_id_i) begin
						keep_r  <= 1'b1;
						bcast_r <= 1'b0;
					end
				end
			end else if (take && st_r == ST_DISP && keep_r) begin
				if (rx_octet_i[`TBF_DISP_TOP] != 2'b01) begin
					keep_r <= 1'b0;
				end else if (rx_octet_i != `TBF_DISP_EXT && rx_octet_i != `TBF_DISP_IPV6
					&& rx_octet_i[`TBF_DISP_HDRC] != 3'b011) begin
					keep_r <= 1'b0;
				end
			end
		end
	end

	// dispatch decode and route report; drop pulses on foreign or reserved
	always_ff @(posedge clk_i or negedge rst_q_b_r) begin
		if (!rst_q_b_r) begin
			route_r     <= RT_NONE;
			dispatch_r  <= 8'h00;
			disp_drop_r <= 1'b0;
		end else begin
			disp_drop_r <= 1'b0;
			if (take && st_r == ST_DISP && keep_r) begin
				dispatch_r <= rx_octet_i;
				if (rx_octet_i[`TBF_DISP_TOP] != 2'b01) begin
					route_r     <= RT_NONE;
					disp_drop_r <= 1'b1;
				end else if (rx_octet_i == `TBF_DISP_IPV6) begin
					route_r <= RT_IPV6;
				end else if (rx_octet_i[`TBF_DISP_HDRC] == 3'b011) begin
					route_r <= RT_HDRC;
				end else if (rx_octet_i != `TBF_DISP_EXT) begin
					route_r     <= RT_NONE;
					disp_drop_r <= 1'b1;
				end
			end else if (take && st_r == ST_ESC && keep_r) begin
				dispatch_r <= rx_octet_i;
				route_r    <= RT_EXT;
			end
		end
	end

	// control frames with no payload are reported to the token logic
	always_ff @(posedge clk_i or negedge rst_q_b_r) begin
		if (!rst_q_b_r) begin
			ctl_evt_r  <= 1'b0;
			ctl_type_r <= 2'b00;
			ctl_src_r  <= 8'h00;
		end else begin
			ctl_evt_r <= 1'b0;
			if (take && st_r == ST_HCRC && len_r == 16'h0000 && ctl_type) begin
				ctl_evt_r  <= 1'b1;
				ctl_type_r <= ftype_r[1:0];
				ctl_src_r  <= src_r;
			end
		end
	end

	// compressed dispatch octet is kept: decoder needs its low bits
	assign pf.wr_vld  = take && keep_r && ((st_r == ST_DATA)
		|| (st_r == ST_DISP && rx_octet_i[`TBF_DISP_HDRC] == 3'b011));
	assign pf.wr_data = {last_oct, rx_octet_i};
	assign pf.rd_rdy  = pay_ready_i;

	tbf_fifo #(.W(9), .D(FIFO_D)) u_fifo (
		.clk_i   (clk_i),
		.rst_b_i (rst_q_b_r),
		.f       (pf.fifo)
	);

	// ready lags level by a cycle, so keep spare room for in-flight octets
	always_ff @(posedge clk_i or negedge rst_q_b_r) begin
		if (!rst_q_b_r) begin
			rx_rdy_r <= 1'b0;
		end else begin
			rx_rdy_r <= pf.level <= LW'(FIFO_D - `TBF_FIFO_SLACK);
		end
	end

	// transmit address policy
	assign uni_ok_dst  = tx_dst_i != `TBF_ID_NONE && tx_dst_i <= `TBF_ID_UNI_MAX;
	assign tx_dst_pick = tx_mcast_i ? `TBF_ID_BCAST : tx_dst_i;
	assign tx_ok       = own_id_i != `TBF_ID_NONE && own_id_i <= `TBF_ID_UNI_MAX
		&& (tx_mcast_i || uni_ok_dst);

	always_ff @(posedge clk_i or negedge rst_q_b_r) begin
		if (!rst_q_b_r) begin
			tx_go_r     <= 1'b0;
			tx_reject_r <= 1'b0;
			tx_mc_r     <= 1'b0;
			tx_ftype_r  <= 8'h00;
			tx_dst_r    <= 8'h00;
			tx_src_r    <= 8'h00;
		end else begin
			tx_go_r     <= tx_req_i && tx_ok;
			tx_reject_r <= tx_req_i && !tx_ok;
			if (tx_req_i && tx_ok) begin
				tx_mc_r    <= tx_mcast_i;
				tx_ftype_r <= `TBF_FT_IPV6;
				tx_dst_r   <= tx_dst_pick;
				tx_src_r   <= own_id_i;
			end
		end
	end

	assign rx_ready_o  = rx_rdy_r;
	assign ctl_evt_o   = ctl_evt_r;
	assign ctl_type_o  = ctl_type_r;
	assign ctl_src_o   = ctl_src_r;
	assign pay_data_o  = pf.rd_data[7:0];
	assign pay_last_o  = pf.rd_data[8];
	assign pay_valid_o = pf.rd_vld;
	assign route_o     = route_r;
	assign dispatch_o  = dispatch_r;
	assign bcast_o     = bcast_r;
	assign addr_err_o  = addr_err_r;
	assign len_err_o   = len_err_r;
	assign disp_drop_o = disp_drop_r;
	assign tx_go_o     = tx_go_r;
	assign tx_reject_o = tx_reject_r;
	assign tx_ftype_o  = tx_ftype_r;
	assign tx_dst_o    = tx_dst_r;
	assign tx_src_o    = tx_src_r;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_q_b_r);

	a_ctl_decode: assert property (
		take && st_r == ST_HCRC && len_r == 16'h0000 && ctl_type
		|=> ctl_evt_o && ctl_type_o == $past(ftype_r[1:0]) && ctl_src_o == $past(src_r))
		else $error("control frame not reported");
	a_bcast_keep: assert property (
		take && st_r == ST_HCRC && ftype_r == `TBF_FT_IPV6 && len_r != 16'h0000
		&& len_r <= `TBF_MAX_LEN && !id_bad && dst_r == `TBF_ID_BCAST
		|=> keep_r && bcast_o)
		else $error("broadcast frame not accepted");
	a_addr_err: assert property (
		take && st_r == ST_HCRC && ftype_r == `TBF_FT_IPV6 && len_r != 16'h0000 && id_bad
		|=> addr_err_o && !keep_r ##1 !addr_err_o)
		else $error("bad node id not flagged");
	a_len_bound: assert property (
		take && st_r == ST_HCRC && ftype_r == `TBF_FT_IPV6 && !id_bad && len_r > `TBF_MAX_LEN
		|=> len_err_o && !keep_r)
		else $error("oversize payload accepted");
	a_foreign_drop: assert property (
		take && st_r == ST_DISP && keep_r && rx_octet_i[7:6] == 2'b00
		|-> !pf.wr_vld ##1 disp_drop_o && !keep_r)
		else $error("foreign payload not discarded");
	a_esc_route: assert property (
		take && st_r == ST_ESC && keep_r
		|=> route_o == RT_EXT && dispatch_o == $past(rx_octet_i))
		else $error("escape dispatch not taken");
	a_hdrc_push: assert property (
		take && st_r == ST_DISP && keep_r && rx_octet_i[7:5] == 3'b011
		|-> pf.wr_vld ##1 route_o == RT_HDRC)
		else $error("compressed header not routed");
	a_crc_end: assert property (
		take && st_r == ST_HCRC && len_r == 16'h0000 |=> st_r == ST_IDLE)
		else $error("empty frame expected payload");
	a_tx_mcast_dst: assert property (
		tx_req_i && tx_mcast_i && tx_ok |=> tx_go_o && tx_dst_o == 8'hFF)
		else $error("multicast not sent to broadcast id");
	a_tx_ids_legal: assert property (
		tx_go_o |-> tx_src_o inside {[8'h01:8'h7F]}
		&& (tx_mc_r || tx_dst_o inside {[8'h01:8'h7F]}))
		else $error("illegal node id sent");

	c_ctl_frame: cover property (ctl_evt_o);
	c_pay_last: cover property (pay_valid_o && pay_ready_i && pay_last_o);
	c_esc_frame: cover property (route_o == RT_EXT && pay_valid_o);
	c_tx_reject: cover property (tx_reject_o);

endmodule : tbf_frame_filter

// ===== sim/tbf_node_model.sv
`timescale 1ns/1ns
// another master node on the bus, handing octets over as the uart would
module tbf_node_model (
	input  wire logic       clk_i,
	input  wire logic       rx_ready_i,
	output logic [7:0]      rx_octet_o,
	output logic            rx_octet_vld_o
);
	int gap = 0;

	// idle line at time zero
	initial begin
		rx_octet_o = 8'h00;
		rx_octet_vld_o = 1'b0;
	end

	// octets in wire order, each held until taken; ready is read at the falling edge so no race
	task automatic send(input logic [7:0] q[$], output bit ok);
		bit rdy;
		int n;
		ok = 1'b1;
		foreach (q[i]) begin
			rx_octet_o = q[i];
			rx_octet_vld_o = 1'b1;
			n = 0;
			do begin
				rdy = rx_ready_i;
				@(posedge clk_i);
				@(negedge clk_i);
				n++;
			end while (!rdy && n < 5000);
			if (!rdy) begin
				ok = 1'b0;
				rx_octet_vld_o = 1'b0;
				return;
			end
			// slow sender: released line alternates between the inverted octet and the old one
			repeat ($urandom_range(gap, 0)) begin
				rx_octet_vld_o = 1'b0;
				rx_octet_o = ~rx_octet_o;
				@(negedge clk_i);
			end
		end
		rx_octet_vld_o = 1'b0;
		rx_octet_o = ~rx_octet_o;
	endtask : send
endmodule : tbf_node_model

// ===== sim/token_bus_ipv6_frame_filter_tb.sv
`timescale 1ns/1ns
`include "tbf_consts.svh"
module token_bus_ipv6_frame_filter_tb import tbf_pkg::*; ;
	logic       clk_i = 1'b0, rst_b_i = 1'b0, pay_ready_i = 1'b0, tx_req_i = 1'b0, tx_mcast_i = 1'b0;
	logic       rx_octet_vld_i, stall = 1'b0, saw_full = 1'b0;
	logic [7:0] own_id_i = 8'h23, rx_octet_i, tx_dst_i = 8'h01;
	logic       rx_ready_o, ctl_evt_o, pay_last_o, pay_valid_o, bcast_o, addr_err_o, len_err_o;
	logic       disp_drop_o, tx_go_o, tx_reject_o;
	logic [1:0] ctl_type_o, route_o;
	logic [7:0] ctl_src_o, pay_data_o, dispatch_o, tx_ftype_o, tx_dst_o, tx_src_o;
	logic [8:0] got_q[$], exp_q[$];
	logic [7:0] bv[5] = '{8'h00, 8'h01, 8'h7F, 8'h80, 8'hFF};
	int         n_fail = 0, checks = 0, n_ae = 0, n_le = 0, n_dd = 0, n_ce = 0;

	tbf_frame_filter #(.FIFO_D(`TBF_FIFO_DEPTH)) u_dut (
		.clk_i (clk_i), .rst_b_i (rst_b_i), .own_id_i (own_id_i), .rx_octet_i (rx_octet_i),
		.rx_octet_vld_i (rx_octet_vld_i), .rx_ready_o (rx_ready_o), .ctl_evt_o (ctl_evt_o),
		.ctl_type_o (ctl_type_o), .ctl_src_o (ctl_src_o), .pay_data_o (pay_data_o), .pay_last_o (pay_last_o),
		.pay_valid_o (pay_valid_o), .pay_ready_i (pay_ready_i), .route_o (route_o), .dispatch_o (dispatch_o),
		.bcast_o (bcast_o), .addr_err_o (addr_err_o), .len_err_o (len_err_o), .disp_drop_o (disp_drop_o),
		.tx_req_i (tx_req_i), .tx_mcast_i (tx_mcast_i), .tx_dst_i (tx_dst_i), .tx_go_o (tx_go_o),
		.tx_reject_o (tx_reject_o), .tx_ftype_o (tx_ftype_o), .tx_dst_o (tx_dst_o), .tx_src_o (tx_src_o)
	);
	tbf_node_model u_node (
		.clk_i          (clk_i),
		.rx_ready_i     (rx_ready_o),
		.rx_octet_o     (rx_octet_i),
		.rx_octet_vld_o (rx_octet_vld_i)
	);

	// 10 MHz system clock
	initial forever #50 clk_i = ~clk_i;

	// consumer stalls at random, or fully while the buffer is being filled
	always @(negedge clk_i) pay_ready_i <= !stall && ($urandom_range(3, 0) != 0);

	// taken payload words and verdict pulses, seen at the edge that takes them
	always @(posedge clk_i) begin
		if (pay_valid_o === 1'b1 && pay_ready_i === 1'b1) got_q.push_back({pay_last_o, pay_data_o});
		if (addr_err_o === 1'b1) n_ae++;
		if (len_err_o === 1'b1) n_le++;
		if (disp_drop_o === 1'b1) n_dd++;
		if (ctl_evt_o === 1'b1) n_ce++;
		if (rst_b_i && rx_ready_o === 1'b0) saw_full = 1'b1;
	end

	task automatic stop_test();
		if (n_fail == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask : chk

	// one header check, back to back with the next call
	task automatic tx_check(input logic [7:0] own, input logic [7:0] dst, input logic mc);
		logic go;
		go = own != 8'h00 && own <= 8'h7F && (mc || (dst != 8'h00 && dst <= 8'h7F));
		own_id_i = own;
		tx_dst_i = dst;
		tx_mcast_i = mc;
		tx_req_i = 1'b1;
		@(negedge clk_i);
		chk(tx_go_o, go, "tx go");
		chk(tx_reject_o, !go, "tx reject");
		if (go) begin
			chk(tx_dst_o, mc ? 8'hFF : dst, "tx dst");
			chk(tx_src_o, own, "tx src");
			chk(tx_ftype_o, 8'h0A, "tx type");
		end
	endtask : tx_check

	// send one frame through the node model and compare with the reference model
	task automatic rx_frame(input logic [7:0] ft, dst, src, d0, d1, input int len);
		logic [7:0] q[$], p[$];
		int         e_ae, e_le, e_dd, e_ce, k, n;
		bit         ok, acc;
		e_ae = n_ae;
		e_le = n_le;
		e_dd = n_dd;
		e_ce = n_ce;
		k = -1;
		acc = 1'b0;
		for (int i = 0; i < len; i++) p.push_back(i == 0 ? d0 : i == 1 ? d1 : 8'($urandom));
		q = {8'h55, 8'hFF, ft, dst, src, 8'(len >> 8), 8'(len), 8'($urandom)};
		q = {q, p};
		if (len != 0) repeat (4) q.push_back(8'($urandom));
		if (ft <= `TBF_FT_POLL_REPLY && len == 0) e_ce++;
		else if (ft == `TBF_FT_IPV6 && len != 0) begin
			if (src == 8'h00 || src == 8'hFF || dst == 8'h00) e_ae++;
			else if (len > 1500) e_le++;
			else if (dst == 8'hFF || dst == own_id_i) begin
				acc = 1'b1;
				k = (d0 == 8'h40) ? 2 : (d0 == 8'h41) ? 1 : (d0[7:5] == 3'b011) ? 0 : -1;
				if (k < 0) e_dd++;
				for (int i = (k < 0) ? len : k; i < len; i++) exp_q.push_back({i == len - 1, p[i]});
			end
		end
		u_node.send(q, ok);
		chk(ok, 1'b1, "octets refused");
		for (n = 0; n < 4000 && got_q.size() < exp_q.size(); n++) @(negedge clk_i);
		repeat (6) @(negedge clk_i);
		chk(got_q.size(), exp_q.size(), "payload count");
		if (!ok || got_q.size() != exp_q.size()) stop_test();
		while (exp_q.size() > 0) chk(got_q.pop_front(), exp_q.pop_front(), "payload");
		chk(n_ae, e_ae, "addr error");
		chk(n_le, e_le, "len error");
		chk(n_dd, e_dd, "dispatch drop");
		chk(n_ce, e_ce, "control event");
		if (acc && k >= 0) begin
			chk(route_o, k == 2 ? RT_EXT : k == 1 ? RT_IPV6 : RT_HDRC, "route");
			chk(dispatch_o, k == 2 ? d1 : d0, "dispatch");
			chk(bcast_o, dst == 8'hFF, "broadcast");
		end
		if (ft <= `TBF_FT_POLL_REPLY && len == 0) begin
			chk(ctl_src_o, src, "control source");
			chk(ctl_type_o, ft[1:0], "control type");
		end
	endtask : rx_frame

	// hang guard
	initial begin
		repeat (100000) @(posedge clk_i);
		n_fail++;
		stop_test();
	end

	initial begin
		logic [7:0] s[$];
		bit         ok;
		void'($urandom(58727));
		repeat (2) @(negedge clk_i);
		chk(rx_ready_o, 1'b0, "ready in reset");
		chk(pay_valid_o, 1'b0, "valid in reset");
		@(negedge clk_i);
		rst_b_i = 1'b1;
		repeat (4) @(negedge clk_i);
		foreach (bv[a]) foreach (bv[b]) for (int m = 0; m < 2; m++) tx_check(bv[a], bv[b], m[0]);
		repeat (40) tx_check(8'($urandom), 8'($urandom), 1'($urandom));
		tx_req_i = 1'b0;
		own_id_i = 8'h23;
		@(negedge clk_i);
		chk(tx_go_o | tx_reject_o, 1'b0, "tx pulse length");
		// broken preamble must fall back to hunting
		s = '{8'h55, 8'h3C, 8'h55};
		u_node.send(s, ok);
		chk(ok, 1'b1, "preamble refused");
		// let the released line show for a cycle before the next frame starts
		@(negedge clk_i);
		rx_frame(`TBF_FT_IPV6, 8'h23, 8'h05, 8'h41, 8'h00, 20);
		rx_frame(`TBF_FT_IPV6, 8'hFF, 8'h7F, 8'h60 | 8'($urandom_range(31, 0)), 8'h00, 9);
		rx_frame(`TBF_FT_IPV6, 8'h23, 8'h01, 8'h40, 8'hC5, 7);
		rx_frame(`TBF_FT_IPV6, 8'h23, 8'h05, 8'($urandom_range(63, 0)), 8'h00, 6);
		rx_frame(`TBF_FT_IPV6, 8'h23, 8'h05, 8'h42 + 8'($urandom_range(29, 0)), 8'h00, 5);
		rx_frame(`TBF_FT_IPV6, 8'h23, 8'h05, 8'h80 | 8'($urandom), 8'h00, 4);
		rx_frame(`TBF_FT_IPV6, 8'h23, 8'h00, 8'h41, 8'h00, 3);
		rx_frame(`TBF_FT_IPV6, 8'h23, 8'hFF, 8'h41, 8'h00, 3);
		rx_frame(`TBF_FT_IPV6, 8'h00, 8'h05, 8'h41, 8'h00, 3);
		rx_frame(`TBF_FT_IPV6, 8'h24, 8'h05, 8'h41, 8'h00, 5);
		rx_frame(`TBF_FT_IPV6, 8'h23, 8'h05, 8'h41, 8'h00, 0);
		rx_frame(`TBF_FT_IPV6, 8'h23, 8'h05, 8'h41, 8'h00, 1501);
		for (int t = 0; t < 3; t++) rx_frame(8'(t), 8'h23, 8'h10 + 8'(t), 8'h00, 8'h00, 0);
		u_node.gap = 3;
		repeat (12) rx_frame(`TBF_FT_IPV6, $urandom_range(1, 0) ? 8'hFF : 8'h23, 8'h11, 8'($urandom),
			8'($urandom), $urandom_range(40, 3));
		// fill the buffer against a stalled consumer, then drain it
		u_node.gap = 0;
		saw_full = 1'b0;
		stall = 1'b1;
		fork
			begin
				repeat (300) @(negedge clk_i);
				stall = 1'b0;
			end
		join_none
		rx_frame(`TBF_FT_IPV6, 8'hFF, 8'h05, 8'h41, 8'h00, 1500);
		chk(saw_full, 1'b1, "buffer never refused");
		chk(pay_valid_o, 1'b0, "buffer not empty");
		stop_test();
	end
endmodule : token_bus_ipv6_frame_filter_tb
